// ### logic/uau_pkg.sv
// Purpose: Shared constants and types for the buffered serial transceiver
// Assumes: 10 MHz system clock, plain register port, 8-bit addresses
// Notes:   Every offset lives here, with field positions and the divider, oversampling and limit reset values
package uau_pkg;
    // Clock and bus
    localparam int CLK_HZ = 10_000_000;
    localparam int AW     = 8;
    localparam int DW     = 32;

    // Register offsets (byte addresses)
    localparam logic [AW-1:0] A_CTRL    = 8'h00;
    localparam logic [AW-1:0] A_BAUD    = 8'h04;
    localparam logic [AW-1:0] A_LIMIT   = 8'h08;
    localparam logic [AW-1:0] A_STAT    = 8'h0C;
    localparam logic [AW-1:0] A_IRQ_ST  = 8'h10;
    localparam logic [AW-1:0] A_IRQ_MSK = 8'h14;
    localparam logic [AW-1:0] A_DATA1   = 8'h20;
    localparam logic [AW-1:0] A_DATA2   = 8'h24;
    localparam logic [AW-1:0] A_DATA3   = 8'h28;
    localparam logic [AW-1:0] A_DATA4   = 8'h2C;

    // Control field positions
    localparam int C_TXEN  = 0;
    localparam int C_RXEN  = 1;
    localparam int C_FLOW  = 2;
    localparam int C_PAREN = 3;
    localparam int C_PODD  = 4;
    localparam int C_MSB   = 5;
    localparam int C_1W    = 6;
    localparam int C_TXFL  = 8;
    localparam int C_RXFL  = 9;

    // Baud, limit and status field positions
    localparam int B_OSR   = 16;
    localparam int L_RX    = 8;
    localparam int S_RXCNT = 8;
    localparam int S_FLAGS = 16;

    // Bit timing; divider is clock cycles per oversample tick
    localparam int BAUD_DEF = 115200;
    localparam int OSR_DEF  = 4;
    localparam int DIV_DEF  = (CLK_HZ + BAUD_DEF * OSR_DEF / 2)
                              / (BAUD_DEF * OSR_DEF);
    localparam logic [15:0] DIV_RST = 16'(DIV_DEF);
    localparam logic [4:0]  OSR_RST = 5'(OSR_DEF);
    localparam logic [4:0]  OSR_MIN = 5'h04;
    localparam logic [4:0]  OSR_MAX = 5'h10;

    // FIFO geometry and limit reset values
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
    localparam logic [CNT_W-1:0] TXLIM_RST = 5'h04;
    localparam logic [CNT_W-1:0] RXLIM_RST = 5'h0C;

    // Interrupt status bits and groups
    localparam int I_SENT = 0;
    localparam int I_TXE  = 1;
    localparam int I_TXL  = 2;
    localparam int I_RCVD = 3;
    localparam int I_RXF  = 4;
    localparam int I_RXL  = 5;
    localparam int I_TXU  = 6;
    localparam int I_RXO  = 7;
    localparam int I_FRM  = 8;
    localparam int I_PAR  = 9;
    localparam int IRQ_W  = 10;
    localparam logic [IRQ_W-1:0] GRP_TX  = 10'h007;
    localparam logic [IRQ_W-1:0] GRP_RX  = 10'h038;
    localparam logic [IRQ_W-1:0] GRP_ERR = 10'h3C0;

    // Serial frame states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100
    } uau_st_e;

    // Line configuration
    typedef struct packed {
        logic        tx_en;
        logic        rx_en;
        logic        flow_en;
        logic        par_en;
        logic        par_odd;
        logic        msb_first;
        logic        one_wire;
        logic [15:0] div;
        logic [4:0]  osr;
    } uau_cfg_s;
endpackage

// ### logic/uau_fifo.sv
// Purpose: Byte FIFO taking or giving up to four bytes per cycle
// Assumes: Caller asks for at most four bytes each way
// Notes:   Requests beyond space or content are trimmed, not stalled
`timescale 1ns/1ps
module uau_fifo (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // Control
    input  wire logic                    flush,
    // Fill side
    input  wire logic [2:0]              push_n,
    input  wire logic [31:0]             push_d,
    // Drain side
    input  wire logic [2:0]              pop_n,
    output logic      [31:0]             peek,
    // Status
    output logic      [uau_pkg::CNT_W-1:0] count
);
    import uau_pkg::*;

    logic [7:0]       mem_r [FIFO_DEPTH];
    logic [3:0]       wp_r;
    logic [3:0]       rp_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] free;
    logic [2:0]       wn;
    logic [2:0]       pn;

    // Trim requests to what fits
    assign free = FIFO_FULL - cnt_r;
    assign wn = (CNT_W'(push_n) > free) ? free[2:0] : push_n;
    assign pn = (CNT_W'(pop_n) > cnt_r) ? cnt_r[2:0] : pop_n;
    assign count = cnt_r;

    // Storage, low byte first
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < wn)
                mem_r[wp_r + 4'(i)] <= push_d[8*i +: 8];
        end
    end

    // Pointers and count; flush wins over traffic
    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wp_r  <= 4'h0;
            rp_r  <= 4'h0;
            cnt_r <= 5'h00;
        end else begin
            wp_r  <= wp_r + 4'(wn);
            rp_r  <= rp_r + 4'(pn);
            cnt_r <= cnt_r + CNT_W'(wn) - CNT_W'(pn);
        end
    end

    // Oldest four bytes
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_peek
            assign peek[8*g +: 8] = mem_r[rp_r + 4'(g)];
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_depth;
        cnt_r <= FIFO_FULL;
    endproperty
    a_depth: assert property (p_depth)
        else $error("fifo count beyond depth");
endmodule

// ### logic/uau_top.sv
// Purpose: Buffered serial transceiver with byte FIFOs and grouped IRQs
// Assumes: Pins synchronous to CLK; one bus strobe per cycle at most
// Notes:   Register port and serial pins share the one clock
`timescale 1ns/1ps
module uau_top (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     SRST,
    // Register port
    input  wire logic [uau_pkg::AW-1:0]   ADDR,
    input  wire logic [uau_pkg::DW-1:0]   WDATA,
    input  wire logic                     WR,
    input  wire logic                     RD,
    output logic      [uau_pkg::DW-1:0]   RDATA,
    // Serial line
    input  wire logic                     RXD,
    output logic                          TXD,
    output logic                          TXD_OE_N,
    input  wire logic                     CTS_N,
    output logic                          RTS_N,
    // Interrupts
    output logic                          IRQ_TX,
    output logic                          IRQ_RX,
    output logic                          IRQ_ERR
);
    import uau_pkg::*;

    uau_cfg_s         cfg_r;
    logic [CNT_W-1:0] txlim_r;
    logic [CNT_W-1:0] rxlim_r;
    logic [IRQ_W-1:0] ist_r;
    logic [IRQ_W-1:0] imsk_r;
    logic [IRQ_W-1:0] ev;
    logic [DW-1:0]    rd_nxt;
    logic [2:0]       acc_n;
    logic             tx_flush;
    logic             rx_flush;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic [31:0]      tx_peek;
    logic [31:0]      rx_peek;
    logic             tx_empty;
    logic             tx_low;
    logic             rx_full;
    logic             rx_high;
    logic [3:0]       flg_q_r;
    logic [15:0]      div_cnt_r;
    logic             tick_r;
    uau_st_e          tx_st_r;
    logic [7:0]       tx_sh_r;
    logic [2:0]       tx_bit_r;
    logic [4:0]       tx_smp_r;
    logic             tx_par_r;
    logic             tx_line_r;
    logic             tx_bit_v;
    logic             tx_go;
    logic             tx_end;
    uau_st_e          rx_st_r;
    logic [7:0]       rx_sh_r;
    logic [2:0]       rx_bit_r;
    logic [4:0]       rx_smp_r;
    logic             rx_pb_r;
    logic             rxd_q_r;
    logic [4:0]       rx_tgt;
    logic             rx_hit;
    logic             rx_done;
    logic [7:0]       rx_byte;

    // Data window size from address
    function automatic logic [2:0] data_n(input logic [AW-1:0] a);
        if (a == A_DATA1)
            data_n = 3'd1;
        else if (a == A_DATA2)
            data_n = 3'd2;
        else if (a == A_DATA3)
            data_n = 3'd3;
        else if (a == A_DATA4)
            data_n = 3'd4;
        else
            data_n = 3'd0;
    endfunction

    // Bit reversal for MSB-first framing
    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            rev8[i] = d[7-i];
    endfunction

    assign acc_n    = data_n(ADDR);
    assign tx_flush = WR && ADDR == A_CTRL && WDATA[C_TXFL];
    assign rx_flush = WR && ADDR == A_CTRL && WDATA[C_RXFL];

    uau_fifo u_txf (
        .clk    (CLK),
        .srst   (SRST),
        .flush  (tx_flush),
        .push_n (WR ? acc_n : 3'd0),
        .push_d (WDATA),
        .pop_n  ({2'b00, tx_go}),
        .peek   (tx_peek),
        .count  (tx_cnt)
    );

    uau_fifo u_rxf (
        .clk    (CLK),
        .srst   (SRST),
        .flush  (rx_flush),
        .push_n ({2'b00, rx_done}),
        .push_d ({24'h000000, rx_byte}),
        .pop_n  (RD ? acc_n : 3'd0),
        .peek   (rx_peek),
        .count  (rx_cnt)
    );

    assign tx_empty = tx_cnt == 5'h00;
    assign tx_low   = tx_cnt < txlim_r;
    assign rx_full  = rx_cnt == FIFO_FULL;
    assign rx_high  = rx_cnt > rxlim_r;

    // Configuration writes; OSR clamped so bit timing stays sane
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg_r   <= '{tx_en: 1'b0, rx_en: 1'b0, flow_en: 1'b0,
                         par_en: 1'b0, par_odd: 1'b0, msb_first: 1'b0,
                         one_wire: 1'b0, div: DIV_RST, osr: OSR_RST};
            txlim_r <= TXLIM_RST;
            rxlim_r <= RXLIM_RST;
            imsk_r  <= '0;
        end else if (WR) begin
            if (ADDR == A_CTRL) begin
                cfg_r.tx_en     <= WDATA[C_TXEN];
                cfg_r.rx_en     <= WDATA[C_RXEN];
                cfg_r.flow_en   <= WDATA[C_FLOW];
                cfg_r.par_en    <= WDATA[C_PAREN];
                cfg_r.par_odd   <= WDATA[C_PODD];
                cfg_r.msb_first <= WDATA[C_MSB];
                cfg_r.one_wire  <= WDATA[C_1W];
            end else if (ADDR == A_BAUD) begin
                // divider of zero acts as one
                cfg_r.div <= (WDATA[15:0] == 16'h0000) ? 16'h0001
                                                      : WDATA[15:0];
                if (WDATA[B_OSR +: 5] < OSR_MIN)
                    cfg_r.osr <= OSR_MIN;
                else if (WDATA[B_OSR +: 5] > OSR_MAX)
                    cfg_r.osr <= OSR_MAX;
                else
                    cfg_r.osr <= WDATA[B_OSR +: 5];
            end else if (ADDR == A_LIMIT) begin
                txlim_r <= WDATA[CNT_W-1:0];
                rxlim_r <= WDATA[L_RX +: CNT_W];
            end else if (ADDR == A_IRQ_MSK) begin
                imsk_r <= WDATA[IRQ_W-1:0];
            end
        end
    end

    // Read mux; FIFO bytes beyond content read as zero
    always_comb begin
        rd_nxt = '0;
        if (ADDR == A_CTRL) begin
            rd_nxt[6:0] = {cfg_r.one_wire, cfg_r.msb_first,
                           cfg_r.par_odd, cfg_r.par_en, cfg_r.flow_en,
                           cfg_r.rx_en, cfg_r.tx_en};
        end else if (ADDR == A_BAUD) begin
            rd_nxt = {11'h000, cfg_r.osr, cfg_r.div};
        end else if (ADDR == A_LIMIT) begin
            rd_nxt[CNT_W-1:0]     = txlim_r;
            rd_nxt[L_RX +: CNT_W] = rxlim_r;
        end else if (ADDR == A_STAT) begin
            rd_nxt[CNT_W-1:0]        = tx_cnt;
            rd_nxt[S_RXCNT +: CNT_W] = rx_cnt;
            rd_nxt[S_FLAGS +: 6]     = {rx_st_r != ST_IDLE,
                                        tx_st_r != ST_IDLE,
                                        rx_high, rx_full,
                                        tx_low, tx_empty};
        end else if (ADDR == A_IRQ_ST) begin
            rd_nxt[IRQ_W-1:0] = ist_r;
        end else if (ADDR == A_IRQ_MSK) begin
            rd_nxt[IRQ_W-1:0] = imsk_r;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < acc_n && CNT_W'(i) < rx_cnt)
                    rd_nxt[8*i +: 8] = rx_peek[8*i +: 8];
            end
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge CLK) begin
        if (SRST || !RD)
            RDATA <= '0;
        else
            RDATA <= rd_nxt;
    end

    always_ff @(posedge CLK) begin
        if (SRST || div_cnt_r >= cfg_r.div - 16'h0001) begin
            div_cnt_r <= 16'h0000;
            tick_r    <= !SRST;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
            tick_r    <= 1'b0;
        end
    end

    // with flow control on, no new character while CTS inactive
    assign tx_go  = tx_st_r == ST_IDLE && cfg_r.tx_en && !tx_empty
                    && (!cfg_r.flow_en || !CTS_N);
    assign tx_end = tick_r && tx_smp_r == cfg_r.osr - 5'h01;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_st_r  <= ST_IDLE;
            tx_sh_r  <= 8'h00;
            tx_bit_r <= 3'h0;
            tx_smp_r <= 5'h00;
            tx_par_r <= 1'b0;
        end else if (tx_st_r == ST_IDLE) begin
            if (tx_go) begin
                tx_st_r  <= ST_START;
                tx_smp_r <= 5'h00;
                tx_bit_r <= 3'h0;
                // reverse so bit 0 always leaves first
                tx_sh_r  <= cfg_r.msb_first ? rev8(tx_peek[7:0])
                                            : tx_peek[7:0];
                tx_par_r <= ^tx_peek[7:0] ^ cfg_r.par_odd;
            end
        end else if (tick_r) begin
            tx_smp_r <= tx_end ? 5'h00 : tx_smp_r + 5'h01;
            if (tx_end) begin
                case (tx_st_r)
                    ST_START: tx_st_r <= ST_DATA;
                    ST_DATA: begin
                        tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if (tx_bit_r == 3'h7)
                            tx_st_r <= cfg_r.par_en ? ST_PAR : ST_STOP;
                    end
                    ST_PAR:  tx_st_r <= ST_STOP;
                    default: tx_st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Line level for the current bit
    always_comb begin
        case (tx_st_r)
            ST_START: tx_bit_v = 1'b0;
            ST_DATA:  tx_bit_v = tx_sh_r[0];
            ST_PAR:   tx_bit_v = tx_par_r;
            default:  tx_bit_v = 1'b1;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_line_r <= 1'b1;
            TXD       <= 1'b1;
            TXD_OE_N  <= 1'b0;
        end else begin
            tx_line_r <= tx_bit_v;
            TXD       <= cfg_r.one_wire ? 1'b0 : tx_bit_v;
            TXD_OE_N  <= cfg_r.one_wire ? tx_bit_v : 1'b0;
        end
    end

    // half a bit to the start centre, then whole bits
    assign rx_tgt  = (rx_st_r == ST_START) ? (cfg_r.osr >> 1) - 5'h01
                                           : cfg_r.osr - 5'h01;
    assign rx_hit  = tick_r && rx_smp_r == rx_tgt;
    assign rx_done = rx_hit && rx_st_r == ST_STOP;
    assign rx_byte = cfg_r.msb_first ? rev8(rx_sh_r) : rx_sh_r;

    // receive framing; disabling aborts a frame
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_st_r  <= ST_IDLE;
            rx_sh_r  <= 8'h00;
            rx_bit_r <= 3'h0;
            rx_smp_r <= 5'h00;
            rx_pb_r  <= 1'b0;
            rxd_q_r  <= 1'b1;
        end else begin
            rxd_q_r <= RXD;
            if (!cfg_r.rx_en) begin
                rx_st_r <= ST_IDLE;
            end else if (rx_st_r == ST_IDLE) begin
                if (rxd_q_r && !RXD) begin
                    rx_st_r  <= ST_START;
                    rx_smp_r <= 5'h00;
                    rx_bit_r <= 3'h0;
                end
            end else if (tick_r) begin
                rx_smp_r <= rx_hit ? 5'h00 : rx_smp_r + 5'h01;
                if (rx_hit) begin
                    case (rx_st_r)
                        // Glitch shorter than half a bit is dropped
                        ST_START: rx_st_r <= RXD ? ST_IDLE : ST_DATA;
                        ST_DATA: begin
                            rx_sh_r  <= {RXD, rx_sh_r[7:1]};
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == 3'h7)
                                rx_st_r <= cfg_r.par_en ? ST_PAR
                                                        : ST_STOP;
                        end
                        ST_PAR: begin
                            rx_pb_r <= RXD;
                            rx_st_r <= ST_STOP;
                        end
                        default: rx_st_r <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // RTS dropped while receive FIFO is full
    always_ff @(posedge CLK) begin
        if (SRST)
            RTS_N <= 1'b1;
        else
            RTS_N <= !(cfg_r.flow_en && cfg_r.rx_en && !rx_full);
    end

    // Previous level flags for edge events
    always_ff @(posedge CLK) begin
        if (SRST)
            flg_q_r <= 4'b0011;
        else
            flg_q_r <= {rx_high, rx_full, tx_low, tx_empty};
    end

    always_comb begin
        ev          = '0;
        ev[I_SENT]  = tx_end && tx_st_r == ST_STOP;
        ev[I_TXE]   = tx_empty && !flg_q_r[0];
        ev[I_TXL]   = tx_low && !flg_q_r[1];
        ev[I_RCVD]  = rx_done && !rx_full;
        ev[I_RXF]   = rx_full && !flg_q_r[2];
        ev[I_RXL]   = rx_high && !flg_q_r[3];
        // Transmitter ran dry at the end of a character
        ev[I_TXU]   = ev[I_SENT] && tx_empty && cfg_r.tx_en;
        ev[I_RXO]   = rx_done && rx_full;
        ev[I_FRM]   = rx_done && !RXD;
        ev[I_PAR]   = rx_done && cfg_r.par_en
                      && (rx_pb_r != (^rx_sh_r ^ cfg_r.par_odd));
    end

    // Sticky status; a new event beats the read clear
    always_ff @(posedge CLK) begin
        if (SRST)
            ist_r <= '0;
        else if (RD && ADDR == A_IRQ_ST)
            ist_r <= ev;
        else
            ist_r <= ist_r | ev;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ_TX  <= 1'b0;
            IRQ_RX  <= 1'b0;
            IRQ_ERR <= 1'b0;
        end else begin
            IRQ_TX  <= |(ist_r & imsk_r & GRP_TX);
            IRQ_RX  <= |(ist_r & imsk_r & GRP_RX);
            IRQ_ERR <= |(ist_r & imsk_r & GRP_ERR);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_start;
        tx_st_r == ST_START |=> !tx_line_r;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit not low");

    property p_stop;
        tx_st_r == ST_STOP |=> tx_line_r;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop bit not high");

    property p_par;
        tx_st_r == ST_PAR |=> tx_line_r == $past(tx_par_r);
    endproperty
    a_par: assert property (p_par)
        else $error("parity bit wrong");

    property p_osr;
        cfg_r.osr >= OSR_MIN && cfg_r.osr <= OSR_MAX;
    endproperty
    a_osr: assert property (p_osr)
        else $error("oversampling out of range");

    property p_cts;
        tx_st_r == ST_IDLE && cfg_r.flow_en && CTS_N
            |=> tx_st_r == ST_IDLE;
    endproperty
    a_cts: assert property (p_cts)
        else $error("character started with CTS inactive");

    property p_rts;
        cfg_r.flow_en && rx_full |=> RTS_N;
    endproperty
    a_rts: assert property (p_rts)
        else $error("RTS asserted while full");

    property p_stat;
        RD && ADDR == A_STAT |=> RDATA[CNT_W-1:0] == $past(tx_cnt);
    endproperty
    a_stat: assert property (p_stat)
        else $error("count readback wrong");

    property p_flush;
        tx_flush |=> tx_cnt == 5'h00 && tx_empty;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush left bytes");

    property p_frm;
        rx_done && !RXD |=> ist_r[I_FRM];
    endproperty
    a_frm: assert property (p_frm)
        else $error("framing error lost");

    property p_irq;
        |(ist_r & imsk_r & GRP_ERR) |=> IRQ_ERR;
    endproperty
    a_irq: assert property (p_irq)
        else $error("error interrupt missing");

    c_sent: cover property (ev[I_SENT]);
    c_rcvd: cover property (ev[I_RCVD]);
    c_ovf:  cover property (ev[I_RXO]);
endmodule

// ### bench/uau_peer.sv
// Purpose: Far-end serial peer that captures and sends frames
// Assumes: Bit time of BIT clock cycles, set to match the bench
// Notes:   Captures eleven samples; a ten-bit frame ends in idle high
`timescale 1ns/1ps
module uau_peer (
    // Clock
    input  wire logic        clk,
    // Serial line
    input  wire logic        txd,
    output logic             rxd
);
    localparam int BIT = 8;
    logic [10:0] frame;
    int          nrx = 0;
    // Idle line is high between frames
    initial rxd = 1'b1;
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            frame = {txd, frame[10:1]};
            repeat (BIT) @(posedge clk);
        end
        nrx++;
    end
    task automatic send(input logic [10:0] f, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask
endmodule

// ### bench/test_uau_top.sv
// Purpose: Register-level test of the buffered serial transceiver
// Assumes: Divider set to 2 with four samples, eight cycles a bit
// Notes:   Peer frames hold the start bit in bit 0
`timescale 1ns/1ps
module test_uau_top;
    import uau_pkg::*;
    logic          CLK = 0, SRST = 1, WR = 0, RD = 0, CTS_N = 1;
    logic [AW-1:0] ADDR = '0;
    logic [DW-1:0] WDATA = '0, rd;
    logic [DW-1:0] RDATA;
    logic          RXD, TXD, TXD_OE_N, RTS_N, IRQ_TX, IRQ_RX, IRQ_ERR;
    logic          peer_rxd, ow = 0;
    // Pad with pull-up; single wire ties the receiver to it
    wire           pad = TXD_OE_N | TXD;
    assign RXD = peer_rxd & (pad | !ow);
    int            errors = 0, samples_checked = 0, n;
    logic [10:0]   fr [3] = '{11'h4B4, 11'h6B4, 11'h0B4};
    logic [9:0]    ex [3] = '{10'h008, 10'h208, 10'h108};
    uau_top u_uau_top (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD),
        .TXD_OE_N(TXD_OE_N), .CTS_N(CTS_N), .RTS_N(RTS_N),
        .IRQ_TX(IRQ_TX), .IRQ_RX(IRQ_RX), .IRQ_ERR(IRQ_ERR));
    uau_peer u_uau_peer (.clk(CLK), .txd(pad), .rxd(peer_rxd));
    // 100 ns clock
    initial forever #50 CLK = ~CLK;
    task automatic chk(input string s, input logic [DW-1:0] e, v);
        samples_checked++;
        if (v !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, v);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] m, e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 rd = RDATA;
        chk($sformatf("reg %h", a), e, rd & m);
    endtask
    // Bounded wait for the peer to finish a frame
    task automatic wait_rx(input int n0);
        for (int i = 0; i < 400 && u_uau_peer.nrx == n0; i++)
            @(posedge CLK);
        if (u_uau_peer.nrx == n0) begin
            errors++;
            $display("[FAIL] peer frame expected 1 seen 0");
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #3_000_000;
        errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        rdc(A_BAUD, '1, 32'h0004_0016);
        rdc(A_LIMIT, '1, 32'h0000_0C04);
        rdc(A_STAT, '1, 32'h0003_0000);
        rdc(8'h3C, '1, '0);
        chk("rts", 1, RTS_N);
        wr(A_BAUD, 32'h0004_0002);
        wr(A_IRQ_MSK, 32'h0000_03FF);
        // Three bytes held back, then flushed
        wr(A_DATA3, 32'h00C3_B2A1);
        rdc(A_STAT, 32'h1F, 32'h3);
        wr(A_CTRL, 32'h100);
        rdc(A_STAT, 32'h1F, 32'h0);
        // Even parity, least significant bit first
        n = u_uau_peer.nrx;
        wr(A_DATA1, 32'hA1);
        wr(A_CTRL, 32'h09);
        wait_rx(n);
        chk("tx frame", 32'h742, 32'(u_uau_peer.frame));
        chk("irq tx", 1, IRQ_TX);
        rdc(A_IRQ_ST, 32'h41, 32'h41);
        // Flow control holds the character until clear to send
        wr(A_CTRL, 32'h3F);
        wr(A_DATA1, 32'h01);
        repeat (40) @(posedge CLK);
        chk("cts hold", 1, TXD);
        chk("rts", 0, RTS_N);
        n = u_uau_peer.nrx;
        CTS_N <= 1'b0;
        wait_rx(n);
        chk("msb frame", 32'h500, 32'(u_uau_peer.frame));
        // Receive good, bad parity and bad stop
        wr(A_CTRL, 32'h0A);
        rdc(A_IRQ_ST, 32'h3C1, 32'h041);
        for (int i = 0; i < 3; i++) begin
            u_uau_peer.send(fr[i], 11);
            repeat (4) @(posedge CLK);
            chk("irq rx", 1, IRQ_RX);
            chk("irq err", i > 0, IRQ_ERR);
            rdc(A_DATA1, 32'hFF, 32'h5A);
            rdc(A_IRQ_ST, 32'h308, 32'(ex[i]));
        end
        // Single wire: own frame on the pad, looped back to receive
        ow <= 1'b1;
        wr(A_CTRL, 32'h43);
        rdc(A_CTRL, '1, 32'h43);
        chk("oe idle", 1, TXD_OE_N);
        n = u_uau_peer.nrx;
        wr(A_DATA1, 32'h5A);
        wait_rx(n);
        chk("1w frame", 32'h6B4, 32'(u_uau_peer.frame));
        rdc(A_DATA1, 32'hFF, 32'h5A);
        end_of_test();
    end
endmodule
